// *** stcmb_consts.svh ***
// Purpose: Offsets, field positions, reset values and codes of the status calendar block
// Assumes: Byte-wide registers at their printed system bus byte addresses
// Notes: Definitions only
`ifndef STCMB_CONSTS_SVH
`define STCMB_CONSTS_SVH

// ==========================================================
// Register and memory byte addresses
`define STCMB_A_CTRL 18'h3_0916
`define STCMB_A_MEMSEL 18'h3_0917
`define STCMB_A_REPEAT 18'h3_0921
`define STCMB_A_LEN_LO 18'h3_0922
`define STCMB_A_LEN_HI 18'h3_0923
`define STCMB_A_STARV 18'h3_0924
`define STCMB_A_HUNGRY 18'h3_0925
`define STCMB_A_STATUS 18'h3_0926
`define STCMB_A_THRESH 18'h3_0945
`define STCMB_A_MAIN_LO 18'h3_1000
`define STCMB_A_MAIN_HI 18'h3_13FE
`define STCMB_A_SHAD_LO 18'h3_1400
`define STCMB_A_SHAD_HI 18'h3_17FE
`define STCMB_A_DESC_LO 18'h3_2000
`define STCMB_A_DESC_HI 18'h3_20FF

// ==========================================================
// Field positions, reset values and memory depths
`define STCMB_B_SW_EN 0
`define STCMB_B_MIN_BURST 3
`define STCMB_B_MEM_SEL 0
`define STCMB_RST_BYTE 8'h00
`define STCMB_CAL_DEPTH 1023
`define STCMB_PORTS 256

// ==========================================================
// Status channel codes and segment block size
`define STCMB_ST_STARVING 2'h0
`define STCMB_ST_HUNGRY 2'h1
`define STCMB_ST_SATISFIED 2'h2
`define STCMB_ST_FRAME 2'h3
`define STCMB_SEL_MAIN 2'h1
`define STCMB_SEL_SHADOW 2'h2
`define STCMB_BLOCK_BYTES 8'h10

`endif

// *** stcmb_pkg.sv ***
// Purpose: Types shared by the status calendar block
// Assumes: Nothing
// Notes: Constants live in stcmb_consts.svh
`default_nettype none

package stcmb_pkg;
  typedef enum logic [1:0] {CAL_HUNT, CAL_SEL, CAL_SLOT, CAL_TAIL} stcmb_cal_e;
  typedef enum logic {SEG_IDLE, SEG_RUN} stcmb_seg_e;
  typedef logic [9:0] stcmb_idx_t;
endpackage

`default_nettype wire

// *** stcmb_link_rx.sv ***
// Purpose: Samples the status pins on the link clock and hands each word to the core clock
// Assumes: Link clock runs freely and is slower than a third of the core clock
// Notes: Toggle handshake; the word register is stable for a full link period after each toggle
`default_nettype none
`include "stcmb_consts.svh"

module stcmb_link_rx (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic core_clk,
  input wire logic core_rst_n,
  input wire logic [1:0] tstat_pin,
  output logic ev_pulse,
  output logic [1:0] ev_word
);
  logic lrst_m, lrst_n;
  logic [1:0] stat_s1, stat_s2, hold_word;
  logic tgl, tgl_s1, tgl_s2, tgl_s3;

  // ==========================================================
  // Link domain
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_m <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_m <= 1'b1;
      lrst_n <= lrst_m;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      stat_s1 <= `STCMB_ST_FRAME;
      stat_s2 <= `STCMB_ST_FRAME;
      hold_word <= `STCMB_ST_FRAME;
      tgl <= 1'b0;
    end else begin
      stat_s1 <= tstat_pin;
      stat_s2 <= stat_s1;
      hold_word <= stat_s2;
      tgl <= ~tgl;
    end
  end

  // ==========================================================
  // Core domain
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      ev_pulse <= 1'b0;
      ev_word <= `STCMB_ST_FRAME;
    end else begin
      tgl_s1 <= tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      ev_pulse <= tgl_s2 ^ tgl_s3;
      if (tgl_s2 ^ tgl_s3) begin
        ev_word <= hold_word;
      end
    end
  end
endmodule

`default_nettype wire

// *** stcmb_top.sv ***
// Purpose: Transmit status calendar, per-port credit and minimum-burst segment shaping
// Assumes: Fabric FIFO inputs are on core_clk; status pins are on tstat_clk
// Notes: Calendar and port descriptor memories are written over the byte-wide system bus
// Operation
// - With memory select bit 0 set, a write at calendar base plus n lands in calendar entry n.
// - Main calendar has 1023 entries up to byte address 0x313FE.
// - Shadow calendar of equal depth spans 0x31400 to 0x317FE.
// - Each calendar entry holds an eight-bit port identifier.
// - Sequence repeats the programmed repeat count between framing patterns.
// - With switch enable set, a select word follows each framing pattern.
// - Select word 01 picks main calendar, 10 picks shadow calendar.
// - Segments carry sixteen times the port's burst value in bytes.
// - End of packet ends the current segment early, on a cycle with a block read.
// - Minimum-burst mode stops short segments from thin FIFO data.
// - A SATISFIED poll lowers the port credit by its burst value when the credit covers it.
// - Credit below burst value ends the port's poll.
// - HUNGRY or STARVING shown only after credit was reloaded.
// - Status 00 STARVING, 01 HUNGRY, 10 SATISFIED, 11 framing.
// - Status update loads credit from starving or hungry value.
`default_nettype none
`include "stcmb_consts.svh"

module stcmb_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tstat_clk,
  input wire logic [1:0] tstat_pin,
  input wire logic [17:0] sys_addr,
  input wire logic sys_wr,
  input wire logic sys_rd,
  input wire logic [7:0] sys_wdata,
  output logic [7:0] sys_rdata,
  output logic sys_ack,
  input wire logic [7:0] tx_fifo_blocks,
  input wire logic tx_fifo_eop,
  output logic [7:0] serviced_port_id_out,
  output logic [1:0] serviced_port_stat_out,
  output logic [3:0] serviced_port_blocks_out,
  output logic poll_active_out,
  output logic shadow_active_out,
  output logic seg_block_rd,
  output logic seg_last,
  output logic [7:0] seg_bytes_out,
  output logic [2:0] tx_fifo_low_threshold_out
);

  // ==========================================================
  // Helpers
  function automatic logic in_range(input logic [17:0] a, input logic [17:0] lo, input logic [17:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic stcmb_pkg::stcmb_idx_t mem_idx(input logic [17:0] a, input logic [17:0] base);
    return 10'(a - base);
  endfunction

  // ==========================================================
  // Reset release
  logic rst_m, rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_sync_n <= rst_m;
    end
  end

  // ==========================================================
  // Status link crossing
  logic ev_pulse;
  logic [1:0] ev_word;

  stcmb_link_rx u_link_rx (
    .link_clk(tstat_clk),
    .rst_n(rst_n),
    .core_clk(core_clk),
    .core_rst_n(rst_sync_n),
    .tstat_pin(tstat_pin),
    .ev_pulse(ev_pulse),
    .ev_word(ev_word)
  );

  // ==========================================================
  // Registers
  logic [7:0] tx_calendar_switch_and_min_burst_ctrl;
  logic [7:0] tx_calendar_memory_select;
  logic [7:0] tx_main_calendar_repeat_count;
  logic [7:0] tx_main_calendar_length_lo;
  logic [7:0] tx_main_calendar_length_hi;
  logic [7:0] tx_fifo_low_threshold;
  logic [7:0] starving_credit_value;
  logic [7:0] hungry_credit_value;
  logic [9:0] main_calendar_length;
  logic tx_calendar_switch_enable;
  logic min_burst_en;
  logic cal_wr_main, cal_wr_shad, desc_wr;
  stcmb_pkg::stcmb_idx_t main_widx, shad_widx;

  assign main_calendar_length = {tx_main_calendar_length_hi[1:0], tx_main_calendar_length_lo};
  assign tx_calendar_switch_enable = tx_calendar_switch_and_min_burst_ctrl[`STCMB_B_SW_EN];
  assign min_burst_en = tx_calendar_switch_and_min_burst_ctrl[`STCMB_B_MIN_BURST];
  assign tx_fifo_low_threshold_out = tx_fifo_low_threshold[2:0];

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_calendar_switch_and_min_burst_ctrl <= `STCMB_RST_BYTE;
      tx_calendar_memory_select <= `STCMB_RST_BYTE;
      tx_main_calendar_repeat_count <= `STCMB_RST_BYTE;
      tx_main_calendar_length_lo <= `STCMB_RST_BYTE;
      tx_main_calendar_length_hi <= `STCMB_RST_BYTE;
      tx_fifo_low_threshold <= `STCMB_RST_BYTE;
      starving_credit_value <= `STCMB_RST_BYTE;
      hungry_credit_value <= `STCMB_RST_BYTE;
    end else if (sys_wr) begin
      case (sys_addr)
        `STCMB_A_CTRL: tx_calendar_switch_and_min_burst_ctrl <= sys_wdata;
        `STCMB_A_MEMSEL: tx_calendar_memory_select <= sys_wdata;
        `STCMB_A_REPEAT: tx_main_calendar_repeat_count <= sys_wdata;
        `STCMB_A_LEN_LO: tx_main_calendar_length_lo <= sys_wdata;
        `STCMB_A_LEN_HI: tx_main_calendar_length_hi <= sys_wdata;
        `STCMB_A_THRESH: tx_fifo_low_threshold <= sys_wdata;
        `STCMB_A_STARV: starving_credit_value <= sys_wdata;
        `STCMB_A_HUNGRY: hungry_credit_value <= sys_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Calendar and port memories
  // Eight-bit port identifiers
  logic [7:0] main_cal [0:`STCMB_CAL_DEPTH-1];
  logic [7:0] shadow_cal [0:`STCMB_CAL_DEPTH-1];
  logic [3:0] port_descriptor_memory [0:`STCMB_PORTS-1];
  logic [7:0] credit_mem [0:`STCMB_PORTS-1];

  assign main_widx = mem_idx(sys_addr, `STCMB_A_MAIN_LO);
  assign shad_widx = mem_idx(sys_addr, `STCMB_A_SHAD_LO);
  assign cal_wr_main = sys_wr && tx_calendar_memory_select[`STCMB_B_MEM_SEL]
    && in_range(sys_addr, `STCMB_A_MAIN_LO, `STCMB_A_MAIN_HI);
  assign cal_wr_shad = sys_wr && tx_calendar_memory_select[`STCMB_B_MEM_SEL]
    && in_range(sys_addr, `STCMB_A_SHAD_LO, `STCMB_A_SHAD_HI);
  assign desc_wr = sys_wr && in_range(sys_addr, `STCMB_A_DESC_LO, `STCMB_A_DESC_HI);

  // No reset on memories; software programs the calendars and descriptors before use, credit loads from status
  always_ff @(posedge core_clk) begin
    if (cal_wr_main) begin
      main_cal[main_widx] <= sys_wdata;
    end
    if (cal_wr_shad) begin
      shadow_cal[shad_widx] <= sys_wdata;
    end
    if (desc_wr) begin
      port_descriptor_memory[sys_addr[7:0]] <= sys_wdata[3:0];
    end
  end

  // ==========================================================
  // Calendar sequencer
  stcmb_pkg::stcmb_cal_e cal_state;
  stcmb_pkg::stcmb_idx_t cal_idx;
  logic [7:0] cal_rep;
  logic use_shadow;
  logic slot_vld;
  logic [7:0] slot_port;
  logic [1:0] slot_stat;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_state <= stcmb_pkg::CAL_HUNT;
      cal_idx <= '0;
      cal_rep <= '0;
      slot_vld <= 1'b0;
      slot_port <= '0;
      slot_stat <= `STCMB_ST_FRAME;
    end else begin
      slot_vld <= 1'b0;
      if (ev_pulse) begin
        unique case (cal_state)
          stcmb_pkg::CAL_HUNT: begin
            cal_idx <= '0;
            cal_rep <= '0;
            if (ev_word == `STCMB_ST_FRAME && main_calendar_length != 10'h000) begin
              cal_state <= tx_calendar_switch_enable ? stcmb_pkg::CAL_SEL : stcmb_pkg::CAL_SLOT;
            end
          end
          stcmb_pkg::CAL_SEL: begin
            // Repeated framing only stretches the frame
            if (ev_word != `STCMB_ST_FRAME) begin
              cal_state <= stcmb_pkg::CAL_SLOT;
            end
          end
          stcmb_pkg::CAL_SLOT: begin
            if (ev_word == `STCMB_ST_FRAME) begin
              // Framing mid-walk restarts it, so an idle link cannot skew the calendar
              cal_idx <= '0;
              cal_rep <= '0;
              cal_state <= tx_calendar_switch_enable ? stcmb_pkg::CAL_SEL : stcmb_pkg::CAL_SLOT;
            end else begin
              slot_vld <= 1'b1;
              slot_port <= use_shadow ? shadow_cal[cal_idx] : main_cal[cal_idx];
              slot_stat <= ev_word;
              if (cal_idx >= main_calendar_length - 10'h001) begin
                cal_idx <= '0;
                if (cal_rep + 8'h01 >= tx_main_calendar_repeat_count) begin
                  cal_state <= stcmb_pkg::CAL_TAIL;
                end else begin
                  cal_rep <= cal_rep + 8'h01;
                end
              end else begin
                cal_idx <= cal_idx + 10'h001;
              end
            end
          end
          stcmb_pkg::CAL_TAIL: begin
            // Parity word skipped, so it is never mistaken for framing
            cal_state <= stcmb_pkg::CAL_HUNT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      use_shadow <= 1'b0;
    end else if (ev_pulse && cal_state == stcmb_pkg::CAL_SEL) begin
      if (ev_word == `STCMB_SEL_MAIN) begin
        use_shadow <= 1'b0;
      end else if (ev_word == `STCMB_SEL_SHADOW) begin
        use_shadow <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Port credit update
  logic [7:0] cur_credit;
  logic [7:0] cur_blocks;
  logic [7:0] next_credit;
  logic stat_upd;

  assign cur_credit = credit_mem[slot_port];
  assign cur_blocks = {4'h0, port_descriptor_memory[slot_port]};

  always_comb begin
    case (slot_stat)
      `STCMB_ST_STARVING: next_credit = starving_credit_value;
      `STCMB_ST_HUNGRY: next_credit = hungry_credit_value;
      `STCMB_ST_SATISFIED: next_credit = (cur_credit >= cur_blocks) ? cur_credit - cur_blocks : cur_credit;
      default: next_credit = cur_credit;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (slot_vld) begin
      credit_mem[slot_port] <= next_credit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      serviced_port_id_out <= '0;
      serviced_port_stat_out <= `STCMB_ST_FRAME;
      serviced_port_blocks_out <= '0;
      poll_active_out <= 1'b0;
      shadow_active_out <= 1'b0;
      stat_upd <= 1'b0;
    end else begin
      shadow_active_out <= use_shadow;
      stat_upd <= slot_vld;
      if (slot_vld) begin
        serviced_port_id_out <= slot_port;
        serviced_port_stat_out <= slot_stat;
        serviced_port_blocks_out <= cur_blocks[3:0];
        poll_active_out <= (slot_stat != `STCMB_ST_FRAME) && (cur_blocks != 8'h00)
          && (next_credit >= cur_blocks);
      end
    end
  end

  // ==========================================================
  // Segment shaping
  stcmb_pkg::stcmb_seg_e seg_state;
  logic [3:0] seg_cnt;
  logic [3:0] seg_blocks;
  logic seg_go;

  // Minimum burst waits for a full burst or end of packet
  assign seg_go = poll_active_out && (serviced_port_blocks_out != 4'h0)
    && (min_burst_en ? ((tx_fifo_blocks >= {4'h0, serviced_port_blocks_out}) || tx_fifo_eop)
                     : (tx_fifo_blocks != 8'h00));

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seg_state <= stcmb_pkg::SEG_IDLE;
      seg_cnt <= '0;
      seg_blocks <= '0;
      seg_block_rd <= 1'b0;
      seg_last <= 1'b0;
      seg_bytes_out <= '0;
    end else begin
      seg_block_rd <= 1'b0;
      seg_last <= 1'b0;
      unique case (seg_state)
        stcmb_pkg::SEG_IDLE: begin
          if (seg_go) begin
            seg_state <= stcmb_pkg::SEG_RUN;
            seg_cnt <= '0;
            seg_blocks <= serviced_port_blocks_out;
            seg_bytes_out <= 8'(serviced_port_blocks_out * `STCMB_BLOCK_BYTES);
          end
        end
        stcmb_pkg::SEG_RUN: begin
          if (tx_fifo_blocks != 8'h00) begin
            seg_block_rd <= 1'b1;
            seg_cnt <= seg_cnt + 4'h1;
            if (seg_cnt == seg_blocks - 4'h1 || tx_fifo_eop) begin
              seg_last <= 1'b1;
              seg_state <= stcmb_pkg::SEG_IDLE;
            end
          end else if (!min_burst_en) begin
            // Without minimum burst an empty FIFO closes a short segment
            seg_last <= 1'b1;
            seg_state <= stcmb_pkg::SEG_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Register read
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    case (sys_addr)
      `STCMB_A_CTRL: next_rdata = tx_calendar_switch_and_min_burst_ctrl;
      `STCMB_A_MEMSEL: next_rdata = tx_calendar_memory_select;
      `STCMB_A_REPEAT: next_rdata = tx_main_calendar_repeat_count;
      `STCMB_A_LEN_LO: next_rdata = tx_main_calendar_length_lo;
      `STCMB_A_LEN_HI: next_rdata = tx_main_calendar_length_hi;
      `STCMB_A_THRESH: next_rdata = tx_fifo_low_threshold;
      `STCMB_A_STARV: next_rdata = starving_credit_value;
      `STCMB_A_HUNGRY: next_rdata = hungry_credit_value;
      `STCMB_A_STATUS: next_rdata = {4'h0, poll_active_out, use_shadow, cal_state};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_rdata <= 8'h00;
      sys_ack <= 1'b0;
    end else begin
      sys_ack <= sys_wr || sys_rd;
      sys_rdata <= sys_rd ? next_rdata : 8'h00;
    end
  end

  // ==========================================================
  // Checks
  chk_cal_write_lands: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    cal_wr_main |=> main_cal[$past(main_widx)] == $past(sys_wdata))
    else $error("main calendar entry not written");

  chk_cal_index_bound: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    cal_state == stcmb_pkg::CAL_SLOT |-> cal_idx < main_calendar_length)
    else $error("calendar index past length");

  chk_repeat_ends_seq: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (ev_pulse && cal_state == stcmb_pkg::CAL_SLOT && ev_word != `STCMB_ST_FRAME
     && cal_idx == main_calendar_length - 10'h001
     && cal_rep + 8'h01 >= tx_main_calendar_repeat_count) |=> cal_state == stcmb_pkg::CAL_TAIL)
    else $error("sequence did not end after repeats");

  chk_sel_word_shadow: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (ev_pulse && cal_state == stcmb_pkg::CAL_SEL && ev_word == `STCMB_SEL_SHADOW) |=> ##1 shadow_active_out)
    else $error("shadow calendar not selected");

  chk_credit_reload: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (slot_vld && slot_stat == `STCMB_ST_STARVING) |=> credit_mem[$past(slot_port)] == $past(starving_credit_value))
    else $error("credit not reloaded on starving");

  chk_credit_satisfied: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (slot_vld && slot_stat == `STCMB_ST_SATISFIED && cur_credit >= cur_blocks)
    |=> credit_mem[$past(slot_port)] == $past(cur_credit) - $past(cur_blocks))
    else $error("credit not lowered on satisfied");

  chk_hungry_shown: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (stat_upd && serviced_port_stat_out == `STCMB_ST_HUNGRY)
    |-> credit_mem[serviced_port_id_out] == hungry_credit_value)
    else $error("hungry shown before credit reload");

  chk_poll_end: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    stat_upd |-> (poll_active_out -> credit_mem[serviced_port_id_out] >= {4'h0, serviced_port_blocks_out}))
    else $error("poll active with credit below burst");

  chk_seg_length: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    seg_state == stcmb_pkg::SEG_RUN |-> seg_cnt < seg_blocks)
    else $error("segment longer than burst");

  chk_min_burst_start: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (seg_state == stcmb_pkg::SEG_IDLE && min_burst_en ##1 seg_state == stcmb_pkg::SEG_RUN)
    |-> ($past(tx_fifo_blocks) >= {4'h0, $past(serviced_port_blocks_out)}) || $past(tx_fifo_eop))
    else $error("short segment started in minimum burst");

endmodule

`default_nettype wire

// *** stcmb_far_dev.sv ***
// Purpose: Status source model for the far receive device
// Assumes: Link clock runs freely
// Notes: Idle words show framing, as a disabled link would
`default_nettype none

module stcmb_far_dev (
  input wire logic tstat_clk,
  output logic [1:0] tstat_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] q[$];
  // ==========================================================
  // Frame build
  // Select word follows frame
  task automatic frame(input logic [1:0] sel, input logic [15:0] w, input int n);
    q.push_back(2'h3);
    q.push_back(sel);
    for (int i = 0; i < n; i++) begin
      q.push_back(w[2*i+:2]);
    end
    // Parity slot, content unused by the block
    q.push_back(2'h0);
  endtask
  // ==========================================================
  // Link drive
  // Framing code while idle
  always @(posedge tstat_clk) begin
    tstat_pin <= (q.size() != 0) ? q.pop_front() : 2'h3;
  end
endmodule

`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench of the status calendar block
// Assumes: Design latencies as handed over
// Notes: FIFO fill is held level, so only full or eop segments are judged
`default_nettype none
`include "stcmb_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic tstat_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] tstat_pin;
  logic [17:0] sys_addr = 18'h0_0000;
  logic sys_wr = 1'b0;
  logic sys_rd = 1'b0;
  logic [7:0] sys_wdata = 8'h00;
  logic [7:0] sys_rdata, id_o, bytes_o, fb = 8'h00;
  logic sys_ack, eop = 1'b0, poll, shad, brd, last;
  logic [1:0] st_o;
  logic [3:0] bl_o;
  logic [2:0] thr_o;
  int errors = 0;
  int comparisons = 0;

  always #10 core_clk = ~core_clk;
  always #40 tstat_clk = ~tstat_clk;

  stcmb_far_dev far_u (.tstat_clk(tstat_clk), .tstat_pin(tstat_pin));

  stcmb_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .tstat_clk(tstat_clk), .tstat_pin(tstat_pin),
    .sys_addr(sys_addr), .sys_wr(sys_wr), .sys_rd(sys_rd), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
    .sys_ack(sys_ack), .tx_fifo_blocks(fb), .tx_fifo_eop(eop), .serviced_port_id_out(id_o),
    .serviced_port_stat_out(st_o), .serviced_port_blocks_out(bl_o), .poll_active_out(poll),
    .shadow_active_out(shad), .seg_block_rd(brd), .seg_last(last), .seg_bytes_out(bytes_o),
    .tx_fifo_low_threshold_out(thr_o));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sys_addr <= a;
    sys_wdata <= d;
    sys_wr <= w;
    sys_rd <= !w;
    @(posedge core_clk);
    sys_wr <= 1'b0;
    sys_rd <= 1'b0;
    @(posedge core_clk);
    chk(8'(sys_ack), 8'h01, "ack");
    if (!w) begin
      chk(sys_rdata, d, "read data");
    end
  endtask

  // Waits for the slot, then one more cycle so poll state has landed
  task automatic slot(input logic [7:0] id, input logic [7:0] st, input logic [7:0] bl, input logic [7:0] pa);
    int n;
    n = 0;
    while (!(id_o === id && 8'(st_o) === st) && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    chk(id_o, id, "slot port");
    chk(8'(st_o), st, "slot status");
    chk(8'(bl_o), bl, "slot burst");
    chk(8'(poll), pa, "poll active");
  endtask

  task automatic seg(input logic [7:0] b, input logic e, input logic [7:0] exp);
    int n;
    logic [7:0] k;
    n = 0;
    k = 8'h00;
    @(posedge core_clk);
    fb <= b;
    eop <= e;
    while (n < 40 && last !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (brd === 1'b1) k++;
    end
    fb <= 8'h00;
    eop <= 1'b0;
    chk(k, exp, "segment blocks");
    chk(8'(last === 1'b1), 8'(exp != 8'h00), "segment end");
  endtask

  task automatic complete_run;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    acc(1, `STCMB_A_MEMSEL, 8'h01);
    acc(1, `STCMB_A_MAIN_LO, 8'h03);
    acc(1, `STCMB_A_MAIN_LO + 18'h1, 8'h05);
    acc(1, `STCMB_A_SHAD_LO, 8'h05);
    acc(1, `STCMB_A_SHAD_LO + 18'h1, 8'h03);
    acc(1, `STCMB_A_MEMSEL, 8'h00);
    acc(1, `STCMB_A_MAIN_LO, 8'h07);
    acc(1, `STCMB_A_DESC_LO + 18'h3, 8'h04);
    acc(1, `STCMB_A_DESC_LO + 18'h5, 8'h02);
    acc(1, `STCMB_A_STARV, 8'h08);
    acc(1, `STCMB_A_HUNGRY, 8'h0c);
    acc(1, `STCMB_A_LEN_LO, 8'h02);
    acc(1, `STCMB_A_LEN_HI, 8'h00);
    acc(1, `STCMB_A_REPEAT, 8'h01);
    acc(1, `STCMB_A_THRESH, 8'h02);
    acc(1, `STCMB_A_CTRL, 8'h09);
    acc(0, `STCMB_A_CTRL, 8'h09);
    acc(0, `STCMB_A_LEN_LO, 8'h02);
    acc(0, `STCMB_A_THRESH, 8'h02);
    acc(0, 18'h3_0930, 8'h00);
    chk(8'(thr_o), 8'h02, "threshold out");
    far_u.frame(2'h1, 16'h0004, 2);
    slot(8'h03, 8'h00, 8'h04, 8'h01);
    slot(8'h05, 8'h01, 8'h02, 8'h01);
    acc(1, `STCMB_A_REPEAT, 8'h02);
    far_u.frame(2'h1, 16'h00aa, 4);
    slot(8'h03, 8'h02, 8'h04, 8'h01);
    slot(8'h05, 8'h02, 8'h02, 8'h01);
    slot(8'h03, 8'h02, 8'h04, 8'h00);
    slot(8'h05, 8'h02, 8'h02, 8'h01);
    acc(1, `STCMB_A_REPEAT, 8'h01);
    far_u.frame(2'h2, 16'h0001, 2);
    slot(8'h05, 8'h01, 8'h02, 8'h01);
    slot(8'h03, 8'h00, 8'h04, 8'h01);
    chk(8'(shad), 8'h01, "shadow select");
    seg(8'h02, 1'b0, 8'h00);
    seg(8'h04, 1'b0, 8'h04);
    chk(bytes_o, 8'h40, "segment bytes");
    seg(8'h01, 1'b1, 8'h01);
    acc(0, `STCMB_A_STATUS, 8'h0d);
    complete_run;
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    errors++;
    complete_run;
  end
endmodule

`default_nettype wire
